// ### option_config_params.svh
// Constants for the option configuration register bank.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
`ifndef OPTION_CONFIG_PARAMS_SVH
`define OPTION_CONFIG_PARAMS_SVH

// Register indices; byte address is four times the index
`define OPT_B_IDX        8'h1e
`define OPT_A_IDX        8'h1f
`define OPT_ADR_W        8

// Field positions, first option register
`define A_WDOG_PERIOD    7
`define A_MON_IN_STOP    6
`define A_MON_RST_DIS    5
`define A_MON_PWR_DIS    4
`define A_TRIP_SEL       3
`define A_SHORT_REC      2
`define A_STOP_EN        1
`define A_WDOG_DIS       0

// Field positions, second option register
`define B_PULLUP_DIS     7
`define B_EXT_INT_EN     6
`define B_OSC_HI         4
`define B_OSC_LO         3
`define B_RST_PIN_EN     0

// Bits that stay writable after the first write
`define A_FREE_MASK      8'h28
`define B_FREE_MASK      8'h00
// Bits cleared by power-on reset only
`define A_POR_MASK       8'h08
`define B_POR_MASK       8'h01
// Implemented bits of the second register
`define B_IMPL_MASK      8'hd9

// Watchdog timeouts in oscillator cycles
`define WDOG_SHORT_CYC   18'h01ff0
`define WDOG_LONG_CYC    18'h3fff0
// Wakeup intervals in wakeup oscillator cycles
`define WAKE_SHORT_CYC   15'h0200
`define WAKE_LONG_CYC    15'h4000
// Stop recovery lengths in oscillator cycles
`define REC_SHORT_CYC    13'h0020
`define REC_LONG_CYC     13'h1000

`endif

// ### option_config_pkg.sv
// Types for the option configuration register bank.
// Assumes option_config_params.svh for all numbers.
package option_config_pkg;

  typedef enum logic [1:0] {
    OSC_INTERNAL,
    OSC_EXTERNAL,
    OSC_EXT_RC,
    OSC_EXT_XTAL
  } osc_sel_e;

  typedef enum logic {
    REC_IDLE,
    REC_COUNT
  } rec_state_e;

  // Decoded options toward the rest of the chip
  typedef struct packed {
    logic        ext_int_pullup_en;
    logic        ext_int_pin_enable;
    osc_sel_e    osc_sel;
    logic        reset_pin_enable;
    logic        watchdog_enable;
    logic [17:0] watchdog_timeout;
    logic [14:0] wakeup_interval;
    logic        volt_monitor_power;
    logic        volt_monitor_reset_en;
    logic        warning_trip_level;
    logic        stop_instr_enable;
  } opt_out_s;

  // Whole state of the bank
  typedef struct packed {
    logic [7:0]  opt_a;
    logic [7:0]  opt_b;
    logic        written_a;
    logic        written_b;
    logic        ack;
    logic [7:0]  rdat;
    rec_state_e  rec_state;
    logic [12:0] rec_cnt;
    logic        rec_done;
    logic        stop_grant;
    logic        stop_illegal;
    opt_out_s    outs;
  } cfg_state_s;

endpackage

// ### option_config_registers.sv
// Option configuration register bank: two write-once option
// registers on a classic Wishbone slave, plus their decode.
// Assumes the system clock is also the oscillator clock, and
// that reset sources come from logic on the same clock.
//
// What this block does
// - Each option register takes only one write after any reset.
// - Trip level and monitor reset disable bits stay writable always.
// - Second register at index 1e, first register at index 1f.
// - Both registers read back their contents at any time.
// - Pullup control bit one disconnects pullup, zero connects it.
// - External interrupt pin function active only when its bit is one.
// - Oscillator bits: internal, external, external RC, crystal.
// - Reset pin function active only when its select bit is one.
// - Reset pin select bit cleared by power-on reset only.
// - Trip level bit cleared by power-on only; rest by any reset.
// - Watchdog timeout 2^13-2^4 or 2^18-2^4 cycles outside stop.
// - In stop, period bit picks 2^9 or 2^14 wakeup cycles.
// - Monitor runs in stop only if stop bit set, power bit clear.
// - Monitor resets blocked while reset disable bit is one.
// - Monitor powered down while power disable bit is one.
// - Trip bit one selects warning level, zero the reset level.
// - Stop exit delayed 32 cycles if short bit set, else 4096.
// - Stop exit caused by monitor reset always uses long delay.
// - Stop instruction runs only when enabled, else illegal opcode.
// - Watchdog disabled while its disable bit is one.
`include "option_config_params.svh"
`timescale 1ns/100ps
`default_nettype none

module option_config_registers
  import option_config_pkg::*;
(
  input  wire logic        sys_clk_i,              // System clock, 20 MHz
  input  wire logic        rst_i,                  // Any reset, sync, high
  input  wire logic        por_i,                  // Power-on reset, with rst_i
  input  wire logic        wb_cyc_i,               // Bus cycle
  input  wire logic        wb_stb_i,               // Bus strobe
  input  wire logic        wb_we_i,                // Write enable
  input  wire logic [7:0]  wb_adr_i,               // Byte address
  input  wire logic [3:0]  wb_sel_i,               // Byte lane selects
  input  wire logic [31:0] wb_dat_i,               // Write data
  output logic      [31:0] wb_dat_o,               // Read data
  output logic             wb_ack_o,               // Acknowledge
  input  wire logic        stop_mode_i,            // Chip is in stop mode
  input  wire logic        stop_opcode_i,          // Stop opcode decoded, pulse
  input  wire logic        stop_exit_i,            // Stop wake event, pulse
  input  wire logic        mon_reset_exit_i,       // Wake caused by monitor reset
  output logic             stop_grant_o,           // Stop executes, pulse
  output logic             illegal_opcode_o,       // Stop refused, pulse
  output logic             stop_recovered_o,       // Recovery over, pulse
  output logic             stop_recovering_o,      // Recovery delay running
  output logic             ext_int_pullup_en_o,    // Pin pullup connected
  output logic             ext_int_pin_enable_o,   // Pin interrupt function
  output osc_sel_e         osc_sel_o,              // Oscillator source
  output logic             reset_pin_enable_o,     // Pin reset function
  output logic             watchdog_enable_o,      // Watchdog running
  output logic      [17:0] watchdog_timeout_o,     // Timeout, osc cycles
  output logic      [14:0] wakeup_interval_o,      // Wakeup, wake osc cycles
  output logic             volt_monitor_power_o,   // Monitor powered
  output logic             volt_monitor_reset_en_o,// Monitor may reset
  output logic             warning_trip_level_o,   // Warning level selected
  output logic             stop_instr_enable_o     // Stop opcode allowed
);

  //////////////////////////////////////////////////////////////////
  // Helpers

  // Register index hit; low two address bits must be zero
  function automatic logic adr_hit(input logic [7:0] adr,
                                   input logic [7:0] idx);
    logic [7:0] want;
    want = {idx[5:0], 2'b00};
    adr_hit = (adr == want);
  endfunction

  // Write-once merge with always-writable bits
  function automatic logic [7:0] merge_once(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       done,
                                            input logic [7:0] free);
    logic [7:0] mask;
    mask = done ? free : 8'hff;
    merge_once = (new_v & mask) | (old_v & ~mask);
  endfunction

  //////////////////////////////////////////////////////////////////
  // State

  cfg_state_s s_r;
  cfg_state_s s_nxt;

  logic       req;
  logic       hit_a;
  logic       hit_b;
  logic       wr_take;
  logic [7:0] wbyte;
  logic       period_bit;
  logic       short_rec;

  assign req     = wb_cyc_i & wb_stb_i;
  assign hit_a   = adr_hit(wb_adr_i, `OPT_A_IDX);
  assign hit_b   = adr_hit(wb_adr_i, `OPT_B_IDX);
  // Write lands at the edge that carries ack
  assign wr_take = req & wb_we_i & s_r.ack & wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];

  //////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt              = s_r;
    s_nxt.ack          = 1'b0;
    s_nxt.rec_done     = 1'b0;
    s_nxt.stop_grant   = 1'b0;
    s_nxt.stop_illegal = 1'b0;
    period_bit         = s_r.opt_a[`A_WDOG_PERIOD];
    short_rec          = s_r.opt_a[`A_SHORT_REC];

    // Bus answer one cycle after the request
    if (req && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      if (hit_a) begin
        s_nxt.rdat = s_r.opt_a;
      end else if (hit_b) begin
        s_nxt.rdat = s_r.opt_b;
      end else begin
        s_nxt.rdat = 8'h00;
      end
    end

    // Register writes
    if (wr_take && hit_a) begin
      s_nxt.opt_a     = merge_once(s_r.opt_a, wbyte, s_r.written_a,
                                   `A_FREE_MASK);
      s_nxt.written_a = 1'b1;
    end
    if (wr_take && hit_b) begin
      s_nxt.opt_b     = merge_once(s_r.opt_b, wbyte & `B_IMPL_MASK,
                                   s_r.written_b,
                                   `B_FREE_MASK);
      s_nxt.written_b = 1'b1;
    end

    // Stop opcode gating
    if (stop_opcode_i) begin
      if (s_r.opt_a[`A_STOP_EN]) begin
        s_nxt.stop_grant = 1'b1;
      end else begin
        s_nxt.stop_illegal = 1'b1;
      end
    end

    // Stop recovery delay
    unique case (s_r.rec_state)
      REC_IDLE: begin
        if (stop_exit_i || mon_reset_exit_i) begin
          s_nxt.rec_state = REC_COUNT;
          if (short_rec && !mon_reset_exit_i) begin
            s_nxt.rec_cnt = `REC_SHORT_CYC;
          end else begin
            s_nxt.rec_cnt = `REC_LONG_CYC;
          end
        end
      end
      REC_COUNT: begin
        if (mon_reset_exit_i && short_rec) begin
          s_nxt.rec_cnt = `REC_LONG_CYC;
        end else if (s_r.rec_cnt == 13'h0001) begin
          s_nxt.rec_state = REC_IDLE;
          s_nxt.rec_cnt   = 13'h0000;
          s_nxt.rec_done  = 1'b1;
        end else begin
          s_nxt.rec_cnt = s_r.rec_cnt - 13'h0001;
        end
      end
    endcase

    // Decoded options, registered from current contents
    s_nxt.outs.ext_int_pullup_en  = ~s_r.opt_b[`B_PULLUP_DIS];
    s_nxt.outs.ext_int_pin_enable = s_r.opt_b[`B_EXT_INT_EN];
    s_nxt.outs.osc_sel            = osc_sel_e'({s_r.opt_b[`B_OSC_HI],
                                                s_r.opt_b[`B_OSC_LO]});
    s_nxt.outs.reset_pin_enable   = s_r.opt_b[`B_RST_PIN_EN];
    s_nxt.outs.watchdog_enable    = ~s_r.opt_a[`A_WDOG_DIS];

    if (period_bit) begin
      s_nxt.outs.watchdog_timeout = `WDOG_SHORT_CYC;
      s_nxt.outs.wakeup_interval  = `WAKE_SHORT_CYC;
    end else begin
      s_nxt.outs.watchdog_timeout = `WDOG_LONG_CYC;
      s_nxt.outs.wakeup_interval  = `WAKE_LONG_CYC;
    end

    // Monitor power: off when disabled, in stop only if allowed
    if (s_r.opt_a[`A_MON_PWR_DIS]) begin
      s_nxt.outs.volt_monitor_power = 1'b0;
    end else if (stop_mode_i) begin
      s_nxt.outs.volt_monitor_power = s_r.opt_a[`A_MON_IN_STOP];
    end else begin
      s_nxt.outs.volt_monitor_power = 1'b1;
    end
    s_nxt.outs.volt_monitor_reset_en = ~s_r.opt_a[`A_MON_RST_DIS];
    s_nxt.outs.warning_trip_level    = s_r.opt_a[`A_TRIP_SEL];
    s_nxt.outs.stop_instr_enable     = s_r.opt_a[`A_STOP_EN];

    // Synchronous reset; power-on bits survive other resets
    if (rst_i) begin
      s_nxt.opt_a        = s_r.opt_a & `A_POR_MASK;
      s_nxt.opt_b        = s_r.opt_b & `B_POR_MASK;
      if (por_i) begin
        s_nxt.opt_a      = 8'h00;
        s_nxt.opt_b      = 8'h00;
      end
      s_nxt.written_a    = 1'b0;
      s_nxt.written_b    = 1'b0;
      s_nxt.ack          = 1'b0;
      s_nxt.rdat         = 8'h00;
      s_nxt.rec_state    = REC_IDLE;
      s_nxt.rec_cnt      = 13'h0000;
      s_nxt.rec_done     = 1'b0;
      s_nxt.stop_grant   = 1'b0;
      s_nxt.stop_illegal = 1'b0;
      s_nxt.outs         = '0;
      s_nxt.outs.ext_int_pullup_en     = 1'b1;
      s_nxt.outs.watchdog_enable       = 1'b1;
      s_nxt.outs.watchdog_timeout      = `WDOG_LONG_CYC;
      s_nxt.outs.wakeup_interval       = `WAKE_LONG_CYC;
      s_nxt.outs.volt_monitor_power    = 1'b1;
      s_nxt.outs.volt_monitor_reset_en = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk_i) begin
    s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_o                = s_r.ack;
  assign wb_dat_o                = {24'h000000, s_r.rdat};
  assign stop_grant_o            = s_r.stop_grant;
  assign illegal_opcode_o        = s_r.stop_illegal;
  assign stop_recovered_o        = s_r.rec_done;
  assign stop_recovering_o       = (s_r.rec_state == REC_COUNT);
  assign ext_int_pullup_en_o     = s_r.outs.ext_int_pullup_en;
  assign ext_int_pin_enable_o    = s_r.outs.ext_int_pin_enable;
  assign osc_sel_o               = s_r.outs.osc_sel;
  assign reset_pin_enable_o      = s_r.outs.reset_pin_enable;
  assign watchdog_enable_o       = s_r.outs.watchdog_enable;
  assign watchdog_timeout_o      = s_r.outs.watchdog_timeout;
  assign wakeup_interval_o       = s_r.outs.wakeup_interval;
  assign volt_monitor_power_o    = s_r.outs.volt_monitor_power;
  assign volt_monitor_reset_en_o = s_r.outs.volt_monitor_reset_en;
  assign warning_trip_level_o    = s_r.outs.warning_trip_level;
  assign stop_instr_enable_o     = s_r.outs.stop_instr_enable;

endmodule // option_config_registers

`default_nettype wire

// ### option_config_registers_properties.sv
// Checker for the option register bank.
// Bound to option_config_registers; sees only its ports.
`include "option_config_params.svh"
`timescale 1ns/100ps
`default_nettype none
module option_config_checker
  import option_config_pkg::*;
(
  input wire logic        sys_clk_i,               // Clock
  input wire logic        rst_i,                   // Reset
  input wire logic        wb_cyc_i,                // Cycle
  input wire logic        wb_stb_i,                // Strobe
  input wire logic        wb_we_i,                 // Write
  input wire logic [7:0]  wb_adr_i,                // Address
  input wire logic [31:0] wb_dat_o,                // Read data
  input wire logic        wb_ack_o,                // Ack
  input wire logic        stop_mode_i,             // Stop mode
  input wire logic        stop_opcode_i,           // Stop opcode
  input wire logic        stop_exit_i,             // Wake
  input wire logic        mon_reset_exit_i,        // Monitor wake
  input wire logic        stop_grant_o,            // Grant
  input wire logic        illegal_opcode_o,        // Refusal
  input wire logic        stop_recovered_o,        // Recovery done
  input wire logic        stop_recovering_o,       // Recovery running
  input wire logic        ext_int_pullup_en_o,     // Pullup
  input wire logic        ext_int_pin_enable_o,    // Pin interrupt
  input wire osc_sel_e    osc_sel_o,               // Oscillator
  input wire logic        reset_pin_enable_o,      // Pin reset
  input wire logic        watchdog_enable_o,       // Watchdog on
  input wire logic [17:0] watchdog_timeout_o,      // Timeout
  input wire logic [14:0] wakeup_interval_o,       // Wakeup
  input wire logic        volt_monitor_power_o,    // Monitor power
  input wire logic        volt_monitor_reset_en_o, // Monitor reset
  input wire logic        warning_trip_level_o,    // Trip level
  input wire logic        stop_instr_enable_o      // Stop allowed
);
  logic [12:0] cnt;
  logic        forced;

  ////////////////////////////////////////////////////////////
  // Cycles since a recovery was started
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || stop_recovered_o) begin
      cnt    <= 13'h0;
      forced <= 1'b0;
    end else if (cnt != 13'h0) begin
      cnt <= cnt + 13'h1;
    end else if (stop_exit_i || mon_reset_exit_i) begin
      cnt    <= 13'h1;
      forced <= mon_reset_exit_i;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [7:0] adr);
    wb_ack_o && !wb_we_i && wb_adr_i == adr;
  endsequence
  sequence s_run;
    stop_recovering_o [*8];
  endsequence

  AST_ACK_AFTER_REQ: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_ONE_CYCLE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_UNMAPPED_ZERO: assert property (wb_ack_o && !wb_we_i && !(wb_adr_i inside {8'h78, 8'h7c})
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  AST_READ_A: assert property (s_rd(8'h7c) |-> wb_dat_o[31:8] == 24'h0
    && watchdog_enable_o != wb_dat_o[0] && stop_instr_enable_o == wb_dat_o[1]
    && warning_trip_level_o == wb_dat_o[3] && volt_monitor_reset_en_o != wb_dat_o[5]
    && watchdog_timeout_o == (wb_dat_o[7] ? `WDOG_SHORT_CYC : `WDOG_LONG_CYC))
    else $error("first register decode wrong");
  AST_MON_POWER: assert property ((s_rd(8'h7c) ##0 $stable(stop_mode_i))
    |-> volt_monitor_power_o == (!wb_dat_o[4] && (!stop_mode_i || wb_dat_o[6])))
    else $error("monitor power wrong");
  AST_READ_B: assert property (s_rd(8'h78) |-> (wb_dat_o & ~32'h000000d9) == 32'h0
    && ext_int_pullup_en_o != wb_dat_o[7] && ext_int_pin_enable_o == wb_dat_o[6]
    && osc_sel_o == osc_sel_e'(wb_dat_o[4:3]) && reset_pin_enable_o == wb_dat_o[0])
    else $error("second register decode wrong");
  AST_WAKE_PAIR: assert property (watchdog_timeout_o == `WDOG_SHORT_CYC
    ? wakeup_interval_o == `WAKE_SHORT_CYC
    : (watchdog_timeout_o == `WDOG_LONG_CYC && wakeup_interval_o == `WAKE_LONG_CYC))
    else $error("timeout and wakeup disagree");
  AST_STOP_ONE_ANSWER: assert property (stop_opcode_i |=> stop_grant_o != illegal_opcode_o)
    else $error("stop opcode answer wrong");
  AST_STOP_GRANTED: assert property (stop_opcode_i && stop_instr_enable_o |=> stop_grant_o)
    else $error("enabled stop not granted");
  AST_REC_RUNS: assert property ((stop_exit_i || mon_reset_exit_i) && cnt == 13'h0 |=> s_run)
    else $error("recovery not running");
  AST_REC_LENGTH: assert property (stop_recovered_o |-> (cnt inside {`REC_LONG_CYC, `REC_LONG_CYC + 13'h1})
    || (!forced && (cnt inside {`REC_SHORT_CYC, `REC_SHORT_CYC + 13'h1})))
    else $error("recovery length wrong");
endmodule // option_config_checker

bind option_config_registers option_config_checker i_option_config_checker (.*);
`default_nettype wire

// ### tb.sv
// Testbench for the option register bank.
// Drives the Wishbone and stop pins directly; no partner model.
`include "option_config_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  import option_config_pkg::*;
  logic        sys_clk_i, rst_i, por_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, ea, eb, d;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        stop_mode_i, stop_opcode_i, stop_exit_i, mon_reset_exit_i;
  logic        stop_grant_o, illegal_opcode_o, stop_recovered_o, stop_recovering_o;
  logic        ext_int_pullup_en_o, ext_int_pin_enable_o, reset_pin_enable_o;
  logic        watchdog_enable_o, volt_monitor_power_o, volt_monitor_reset_en_o;
  logic        warning_trip_level_o, stop_instr_enable_o, wa, wbf;
  osc_sel_e    osc_sel_o;
  logic [17:0] watchdog_timeout_o;
  logic [14:0] wakeup_interval_o;
  int          fail_count, samples_checked, n, exp_n;

  option_config_registers i_option_config_registers (.*);

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic [7:0] adr, input logic we, input logic [3:0] sel, input logic [7:0] dv);
    int k;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, dv};
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 16);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 16) begin
      fail_count++;
      stop_test();
    end
  endtask

  // Expected register after a write, from the free and implemented masks
  function automatic logic [7:0] upd(input logic [7:0] o, nw, free, impl, input logic done);
    return (done ? ((o & ~free) | (nw & free)) : nw) & impl;
  endfunction

  task automatic wr(input logic isa, input logic [7:0] dv);
    bus(isa ? 8'h7c : 8'h78, 1'b1, 4'h1, dv);
    if (isa) ea = upd(ea, dv, `A_FREE_MASK, 8'hff, wa);
    else eb = upd(eb, dv, `B_FREE_MASK, `B_IMPL_MASK, wbf);
    if (isa) wa = 1'b1;
    else wbf = 1'b1;
  endtask

  task automatic rd_check;
    bus(8'h7c, 1'b0, 4'h0, 8'h00);
    check("reg a", {24'h0, ea}, q);
    bus(8'h78, 1'b0, 4'h0, 8'h00);
    check("reg b", {24'h0, eb}, q);
  endtask

  task automatic do_reset(input logic p);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    por_i <= p;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    ea  = p ? 8'h00 : (ea & `A_POR_MASK);
    eb  = p ? 8'h00 : (eb & `B_POR_MASK);
    wa  = 1'b0;
    wbf = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    {rst_i, por_i} = 2'b11;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {stop_mode_i, stop_opcode_i, stop_exit_i, mon_reset_exit_i} = 4'h0;
    {ea, eb, wa, wbf, fail_count, samples_checked} = '0;
    void'($urandom(9));
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    bus(8'h00, 1'b1, 4'h1, 8'hff);
    bus(8'h00, 1'b0, 4'h1, 8'h00);
    check("unmapped", 32'h0, q);
    for (int r = 0; r < 4; r++) begin
      if (r > 0) do_reset(r == 3);
      stop_mode_i <= r[0];
      rd_check();
      // Write without lane 0 must not lock the register
      bus(8'h7c, 1'b1, 4'h0, 8'hff);
      d = 8'($urandom);
      // Corners: both periods, short and long recovery, stop granted and refused
      {d[7], d[2:1]} = {r[1], r != 1, r[0]};
      wr(1'b1, d);
      d = 8'($urandom);
      // Reset pin bit set so a plain reset must keep it
      {d[4:3], d[0]} = {r[1:0], 1'b1};
      wr(1'b0, d);
      rd_check();
      wr(1'b1, 8'($urandom));
      wr(1'b0, 8'($urandom));
      rd_check();
      check("timeout", ea[7] ? `WDOG_SHORT_CYC : `WDOG_LONG_CYC, watchdog_timeout_o);
      check("osc", r, osc_sel_o);
      @(posedge sys_clk_i);
      stop_opcode_i <= 1'b1;
      @(posedge sys_clk_i);
      stop_opcode_i <= 1'b0;
      @(posedge sys_clk_i);
      check("stop answer", {ea[1], ~ea[1]}, {stop_grant_o, illegal_opcode_o});
      if (r == 2) mon_reset_exit_i <= 1'b1;
      else stop_exit_i <= 1'b1;
      @(posedge sys_clk_i);
      stop_exit_i      <= 1'b0;
      mon_reset_exit_i <= 1'b0;
      n = 0;
      do begin
        @(posedge sys_clk_i);
        n++;
      end while (stop_recovered_o !== 1'b1 && n < 5000);
      if (n >= 5000) begin
        fail_count++;
        stop_test();
      end
      exp_n = (ea[2] && r != 2) ? 32 : 4096;
      check("recovery", 1, n == exp_n || n == exp_n + 1);
    end
    stop_test();
  end
endmodule // tb
`default_nettype wire
